// File: common/hpsr_pkg.sv
// hpsr_pkg: register map, field positions, reset values and timing
// constants for the hub port suspend/resume controller.
// assumes: 8-bit registers on a 32-bit classic wishbone slave.

package hpsr_pkg;

  localparam int NPORTS = 4;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_USC = 8'h1f;
  localparam logic [7:0] IDX_SUSP = 8'h4d;
  localparam logic [7:0] IDX_RES = 8'h4e;
  localparam logic [7:0] IDX_HUBCTL = 8'h60;

  localparam logic [7:0] RST_REG = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int USC_BUSACT = 3;
  localparam int USC_DMINUS = 4;
  localparam int USC_DPLUS = 5;
  localparam int USC_EPMODE = 6;
  localparam int USC_EPSIZE = 7;
  localparam int SUSP_WAKE = 7;

  // upstream drive override codes
  localparam logic [2:0] UP_ENGINE = 3'h0;
  localparam logic [2:0] UP_J = 3'h1;
  localparam logic [2:0] UP_K = 3'h2;
  localparam logic [2:0] UP_SE0 = 3'h3;
  localparam logic [2:0] UP_LOW = 3'h4;
  localparam logic [2:0] UP_ZLO = 3'h5;
  localparam logic [2:0] UP_LOZ = 3'h6;
  localparam logic [2:0] UP_ZZ = 3'h7;

  // downstream force codes
  localparam logic [1:0] DN_NORMAL = 2'h0;
  localparam logic [1:0] DN_DIFF1 = 2'h1;
  localparam logic [1:0] DN_DIFF0 = 2'h2;
  localparam logic [1:0] DN_SE0 = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 10_000_000;
  localparam longint WAKE_HOLD_US = 1000;
  localparam int WAKE_HOLD_CYC = int'((WAKE_HOLD_US * CLK_HZ + 999_999)
                                      / 1_000_000);

  // one usb pin pair: drive value and enable per line
  typedef struct packed {
    logic dp_o;
    logic dp_oe;
    logic dm_o;
    logic dm_oe;
  } hpsr_pin_t;

endpackage

// File: rtl/hpsr_ctrl.sv
// hpsr_ctrl: suspend/resume control for four downstream hub ports
// plus the upstream status and control register.
// assumes: pins already synchronised to nothing; this module adds two
// flip-flops on every pin input. repeater data arrives pre-resolved.
//
// Overview of operation
// - no normal traffic or foreign resume reaches a suspended port
// - resume on suspended port: reflect K, set resume bit, interrupt
// - disconnect on a suspended port clears its suspend bit
// - wakeup enable gates resume propagation for connect/disconnect events
// - remote wakeup always propagates; enable gates the interrupt for connect/disconnect wakes
// - resume is diff one for low speed, diff zero for full speed
// - suspend and resume registers clear on chip or bus reset
// - resume bits low four, read-only, hardware set, upper bits zero
// - clearing suspend clears resume bit and ends hardware resume
// - resume in suspend: K upstream, reflect, interrupt, wake clocks
// - after wake, firmware held off at least 1 ms
// - upstream drive field selects engine, J, K, SE0, low or hi-z
// - bus-activity flag sticky, engine sets, write 0 clears
// - two read-only bits show live upstream D- and D+ levels
// - two read-write bits select endpoint size and address mode
// - upstream status register clears to zero on reset
// - repeater generates end-of-packet at each frame's EOF1 point while its drive is enabled
// - downstream force field: normal, diff one, diff zero, SE0
//
// Implementation choice: the Wishbone register port.

`timescale 1ns/1ns
`default_nettype none

module hpsr_ctrl #(
  parameter int NPORTS = hpsr_pkg::NPORTS,
  parameter int WAKE_HOLD_CYC = hpsr_pkg::WAKE_HOLD_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_bus_reset,
  // wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // upstream
  input wire logic i_up_dp,
  input wire logic i_up_dm,
  input wire logic i_eng_dp,
  input wire logic i_eng_dm,
  input wire logic i_eng_oe,
  input wire logic i_eng_activity,
  input wire logic i_hub_suspended,
  input wire logic i_eof1,
  output hpsr_pkg::hpsr_pin_t o_up,
  // repeater data toward downstream ports
  input wire logic i_rpt_dp,
  input wire logic i_rpt_dm,
  input wire logic i_rpt_oe,
  input wire logic i_rpt_resume,
  // downstream ports
  input wire logic [NPORTS-1:0] i_dn_dp,
  input wire logic [NPORTS-1:0] i_dn_dm,
  input wire logic [NPORTS-1:0] i_dn_low_speed,
  input wire logic [NPORTS-1:0] i_dn_enabled,
  input wire logic [NPORTS-1:0] i_dn_connect_evt,
  input wire logic [NPORTS-1:0] i_dn_disconnect_evt,
  input wire logic [2*NPORTS-1:0] i_dn_force,
  output hpsr_pkg::hpsr_pin_t [NPORTS-1:0] o_dn,
  // hub level
  output logic o_hub_irq,
  output logic o_wake_clocks,
  output logic o_fw_hold
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2*NPORTS+1:0] sync1;
  logic [2*NPORTS+1:0] sync2;
  logic [NPORTS-1:0] dn_dp;
  logic [NPORTS-1:0] dn_dm;
  logic up_dp;
  logic up_dm;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {i_up_dp, i_up_dm, i_dn_dp, i_dn_dm};
      sync2 <= sync1;
    end
  end

  assign {up_dp, up_dm, dn_dp, dn_dm} = sync2;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0] up_drive;
  logic bus_activity;
  logic ep_mode;
  logic ep_size;
  logic [NPORTS-1:0] sel_susp;
  logic remote_wake_en;
  logic [NPORTS-1:0] resume_st;
  logic [NPORTS-1:0] hw_resume;
  logic up_k_drive;
  logic [31:0] wake_cnt;

  logic clr_all;
  assign clr_all = !i_resetn || i_bus_reset;

  // wishbone decode
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign idx = i_wb_adr[9:2];
  assign wdat = i_wb_dat[7:0];
  assign wr = req && i_wb_we && i_wb_sel[0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r) && (i_wb_adr[31:10] == '0) && (i_wb_adr[1:0] == 2'b00);
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= req;
      if (req && !i_wb_we) begin
        if (hit(idx, hpsr_pkg::IDX_USC)) begin
          o_wb_dat <= {24'h00_0000, ep_size, ep_mode, up_dp, up_dm,
                       bus_activity, up_drive};
        end else if (hit(idx, hpsr_pkg::IDX_SUSP)) begin
          o_wb_dat <= {24'h00_0000, remote_wake_en, 3'h0, sel_susp};
        end else if (hit(idx, hpsr_pkg::IDX_RES)) begin
          o_wb_dat <= {28'h000_0000, resume_st};
        end else if (hit(idx, hpsr_pkg::IDX_HUBCTL)) begin
          o_wb_dat <= {30'h0000_0000, o_fw_hold, o_wake_clocks};
        end else begin
          o_wb_dat <= '0;
        end
      end
    end
  end

  // upstream status and control; bus reset leaves it alone
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      up_drive <= 3'h0;
      ep_mode <= 1'b0;
      ep_size <= 1'b0;
    end else if (wr && hit(idx, hpsr_pkg::IDX_USC)) begin
      up_drive <= wdat[2:0];
      ep_mode <= wdat[hpsr_pkg::USC_EPMODE];
      ep_size <= wdat[hpsr_pkg::USC_EPSIZE];
    end
  end

  // engine set beats a same-cycle firmware clear
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      bus_activity <= 1'b0;
    end else if (i_eng_activity) begin
      bus_activity <= 1'b1;
    end else if (wr && hit(idx, hpsr_pkg::IDX_USC) &&
                 !wdat[hpsr_pkg::USC_BUSACT]) begin
      bus_activity <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // selective suspend and resume detection
  // ---------------------------------------------------------------
  logic [NPORTS-1:0] resume_cond;
  logic [NPORTS-1:0] next_sel_susp;
  logic susp_wr;
  assign susp_wr = wr && hit(idx, hpsr_pkg::IDX_SUSP);

  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_det
      // low speed idles J as D-, so its K is D+ high; full speed inverse
      assign resume_cond[p] = i_dn_low_speed[p] ?
                              (dn_dp[p] && !dn_dm[p]) :
                              (!dn_dp[p] && dn_dm[p]);
    end
  endgenerate

  always_comb begin
    next_sel_susp = sel_susp;
    if (susp_wr) begin
      next_sel_susp = wdat[NPORTS-1:0];
    end
    next_sel_susp = next_sel_susp & ~i_dn_disconnect_evt;
  end

  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      sel_susp <= '0;
      remote_wake_en <= 1'b0;
    end else begin
      sel_susp <= next_sel_susp;
      if (susp_wr) begin
        remote_wake_en <= wdat[hpsr_pkg::SUSP_WAKE];
      end
    end
  end

  // a detection in the same cycle as a clear still loses: the port is
  // no longer suspended, so its request is meaningless
  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      resume_st <= '0;
      hw_resume <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (!next_sel_susp[p]) begin
          resume_st[p] <= 1'b0;
          hw_resume[p] <= 1'b0;
        end else if (sel_susp[p] && resume_cond[p]) begin
          resume_st[p] <= 1'b1;
          hw_resume[p] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // global suspend wake and firmware hold-off
  // ---------------------------------------------------------------
  logic wake_evt;
  logic wake_start;
  logic conn_evt;
  logic rmt_evt;
  logic any_new_res;
  assign conn_evt = |(i_dn_connect_evt | i_dn_disconnect_evt);
  assign rmt_evt = |(resume_cond & i_dn_enabled & ~sel_susp);
  assign any_new_res = |(resume_cond & sel_susp & ~resume_st);
  assign wake_evt = i_hub_suspended &&
                    (rmt_evt || (remote_wake_en && conn_evt));
  // a held k must not restart the hold or repeat the interrupt
  assign wake_start = wake_evt && !o_wake_clocks;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      up_k_drive <= 1'b0;
    end else if (wake_evt) begin
      up_k_drive <= 1'b1;
    end else if (!i_hub_suspended) begin
      up_k_drive <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_wake_clocks <= 1'b0;
      wake_cnt <= '0;
      o_fw_hold <= 1'b0;
    end else if (wake_start) begin
      o_wake_clocks <= 1'b1;
      wake_cnt <= 32'(WAKE_HOLD_CYC);
      o_fw_hold <= 1'b1;
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - 32'h0000_0001;
    end else begin
      o_fw_hold <= 1'b0;
      o_wake_clocks <= 1'b0;
    end
  end

  // interrupt pulse; the wakeup enable bit gates only its connect/disconnect wake source
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_hub_irq <= 1'b0;
    end else begin
      o_hub_irq <= any_new_res || wake_start;
    end
  end

  // ---------------------------------------------------------------
  // upstream pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_up <= '0;
    end else if (up_k_drive) begin
      o_up <= '{dp_o: 1'b0, dp_oe: 1'b1, dm_o: 1'b1, dm_oe: 1'b1};
    end else begin
      case (up_drive)
        hpsr_pkg::UP_ENGINE: o_up <= '{dp_o: i_eng_dp, dp_oe: i_eng_oe,
                                       dm_o: i_eng_dm, dm_oe: i_eng_oe};
        hpsr_pkg::UP_J: o_up <= '{1'b1, 1'b1, 1'b0, 1'b1};
        hpsr_pkg::UP_K: o_up <= '{1'b0, 1'b1, 1'b1, 1'b1};
        hpsr_pkg::UP_SE0: o_up <= '{1'b0, 1'b1, 1'b0, 1'b1};
        hpsr_pkg::UP_LOW: o_up <= '{1'b0, 1'b1, 1'b0, 1'b1};
        hpsr_pkg::UP_ZLO: o_up <= '{1'b0, 1'b0, 1'b0, 1'b1};
        hpsr_pkg::UP_LOZ: o_up <= '{1'b0, 1'b1, 1'b0, 1'b0};
        default: o_up <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // downstream pin drive
  // ---------------------------------------------------------------
  logic eop_hold;
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      eop_hold <= 1'b0;
    end else begin
      eop_hold <= i_eof1;
    end
  end

  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_dn
      logic [1:0] frc;
      assign frc = i_dn_force[2*p+1:2*p];
      always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
          o_dn[p] <= '0;
        end else if (frc != hpsr_pkg::DN_NORMAL) begin
          case (frc)
            hpsr_pkg::DN_DIFF1: o_dn[p] <= '{1'b1, 1'b1, 1'b0, 1'b1};
            hpsr_pkg::DN_DIFF0: o_dn[p] <= '{1'b0, 1'b1, 1'b1, 1'b1};
            default: o_dn[p] <= '{1'b0, 1'b1, 1'b0, 1'b1};
          endcase
        end else if (hw_resume[p]) begin
          // reflect K in the port's own speed polarity
          o_dn[p] <= '{dp_o: i_dn_low_speed[p], dp_oe: 1'b1,
                       dm_o: !i_dn_low_speed[p], dm_oe: 1'b1};
        end else if (sel_susp[p] || !i_dn_enabled[p]) begin
          o_dn[p] <= '0;
        end else if (up_k_drive) begin
          o_dn[p] <= '{dp_o: i_dn_low_speed[p], dp_oe: 1'b1,
                       dm_o: !i_dn_low_speed[p], dm_oe: 1'b1};
        end else if (i_rpt_oe && (eop_hold || i_eof1)) begin
          o_dn[p] <= '{1'b0, 1'b1, 1'b0, 1'b1};
        end else if (i_rpt_oe || i_rpt_resume) begin
          o_dn[p] <= '{dp_o: i_rpt_dp, dp_oe: 1'b1,
                       dm_o: i_rpt_dm, dm_oe: 1'b1};
        end else begin
          o_dn[p] <= '0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: tb/hpsr_ctrl_chk.sv
// hpsr_ctrl_chk: port-level assertions for the hub suspend/resume logic.
// assumes: bound to hpsr_ctrl, one clock, sync active-low reset.
`timescale 1ns/1ns
`default_nettype none
module hpsr_ctrl_chk #(
  parameter int WAKE_HOLD_CYC = hpsr_pkg::WAKE_HOLD_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_hub_irq,
  input wire logic o_wake_clocks,
  input wire logic o_fw_hold
);
  // length of the current firmware hold, compared when it ends
  int hold_cnt;
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) hold_cnt <= 0;
    else hold_cnt <= o_fw_hold ? hold_cnt + 1 : 0;
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  property p_ack_next;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_idle_no_ack;
    !i_wb_cyc |=> !o_wb_ack;
  endproperty
  a_idle_no_ack: assert property (p_idle_no_ack) else $error("stray ack");
  property p_dat_stable;
    !o_wb_ack |-> $stable(o_wb_dat);
  endproperty
  a_dat_stable: assert property (p_dat_stable) else $error("data moved");
  property p_res_hi;
    o_wb_ack && $past(i_wb_adr[9:2] == hpsr_pkg::IDX_RES && !i_wb_we)
      |-> o_wb_dat[31:4] == 28'h000_0000;
  endproperty
  a_res_hi: assert property (p_res_hi)
    else $error("resume upper bits set");
  property p_irq_pulse;
    o_hub_irq |=> !o_hub_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq not a pulse");
  property p_hold_len;
    $fell(o_fw_hold) |-> hold_cnt == WAKE_HOLD_CYC + 1;
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("hold length wrong");
  property p_hold_min;
    $rose(o_fw_hold) |-> o_fw_hold [*8];
  endproperty
  a_hold_min: assert property (p_hold_min)
    else $error("hold too short");
  property p_wake_hold;
    o_fw_hold |-> o_wake_clocks;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("clocks off during hold");
  property p_reset_quiet;
    disable iff (1'b0)
    !i_resetn |=> !o_wb_ack && !o_hub_irq && !o_fw_hold && !o_wake_clocks;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset leak");
  c_read: cover property (o_wb_ack && o_wb_dat != 32'h0000_0000);
  c_irq: cover property (o_hub_irq);
  c_hold: cover property ($fell(o_fw_hold));
endmodule
`default_nettype wire

// File: tb/hpsr_dev_model.sv
// hpsr_dev_model: four downstream devices seen at their pins.
// assumes: the bench commands speed, resume k and detach per port.
`timescale 1ns/1ns
`default_nettype none
module hpsr_dev_model (
  input wire logic [3:0] i_ls,
  input wire logic [3:0] i_k,
  input wire logic [3:0] i_se0,
  output logic [3:0] o_dp,
  output logic [3:0] o_dm
);
  // detached lines fall to the pull-downs; else idle j or resume k,
  // k being diff one on low speed and diff zero on full speed
  assign o_dp = ~i_se0 & ~(i_ls ^ i_k);
  assign o_dm = ~i_se0 & (i_ls ^ i_k);
endmodule
`default_nettype wire

// File: tb/hpsr_ctrl_tb.sv
// hpsr_ctrl_tb: self-checking bench for the hub suspend/resume logic.
// assumes: device model on downstream pins, host pins driven here.
`timescale 1ns/1ns
`default_nettype none
module hpsr_ctrl_tb;
  localparam int HOLD = 20;
  logic clk = 1'b0, rstn = 1'b0, busrst = 1'b0, ack, irq, wclk, fwh;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, updp = 1'b0, updm = 1'b0;
  logic edp = 1'b0, edm = 1'b0, eoe = 1'b0, eact = 1'b0, hsusp = 1'b0;
  logic eof1 = 1'b0, rpt_oe = 1'b0, sk;
  logic [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdq;
  logic [3:0] sel = 4'h0, ls = 4'h0, den = 4'hf, conn = 4'h0, disc = 4'h0;
  logic [3:0] mk = 4'h0, mse0 = 4'h0, ddp, ddm;
  logic [7:0] frc = 8'h00, rd, d;
  hpsr_pkg::hpsr_pin_t up;
  hpsr_pkg::hpsr_pin_t [3:0] dn;
  int miscompares = 0, checked = 0, seed = 32'h458b, p, n;
  always #50 clk = ~clk;
  hpsr_ctrl #(.WAKE_HOLD_CYC(HOLD)) hpsr_ctrl_i (.i_core_clk(clk),
    .i_resetn(rstn), .i_bus_reset(busrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdq), .o_wb_ack(ack), .i_up_dp(updp), .i_up_dm(updm),
    .i_eng_dp(edp), .i_eng_dm(edm), .i_eng_oe(eoe), .i_eng_activity(eact),
    .i_hub_suspended(hsusp), .i_eof1(eof1), .o_up(up), .i_rpt_dp(1'b1),
    .i_rpt_dm(1'b0), .i_rpt_oe(rpt_oe), .i_rpt_resume(1'b0),
    .i_dn_dp(ddp), .i_dn_dm(ddm), .i_dn_low_speed(ls), .i_dn_enabled(den),
    .i_dn_connect_evt(conn), .i_dn_disconnect_evt(disc),
    .i_dn_force(frc), .o_dn(dn), .o_hub_irq(irq), .o_wake_clocks(wclk),
    .o_fw_hold(fwh));
  hpsr_dev_model hpsr_dev_model_i (.i_ls(ls), .i_k(mk), .i_se0(mse0),
    .o_dp(ddp), .o_dm(ddm));
  // ---------------------------------------------------------------
  // bus cycles, comparisons, expectations
  // ---------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] dv, input logic s0);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h00_0000, idx, 2'b00};
    wdat <= {24'h00_0000, dv};
    sel <= {3'h0, s0};
    tick(1);
    while (ack !== 1'b1 && t < 20) begin
      tick(1);
      t++;
    end
    if (t == 20) miscompares++;
    rd = rdq[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    tick(1);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 1'b1);
    chk(rd, exp);
  endtask
  // masks a released line so only driven levels are compared
  function automatic logic [7:0] nm(input hpsr_pkg::hpsr_pin_t x);
    return {4'h0, x.dp_o & x.dp_oe, x.dp_oe, x.dm_o & x.dm_oe, x.dm_oe};
  endfunction
  function automatic logic [7:0] drv(input logic [2:0] c);
    logic [3:0] t [8];
    t = '{4'h0, 4'hd, 4'h7, 4'h5, 4'h5, 4'h1, 4'h4, 4'h0};
    if (c == hpsr_pkg::UP_ENGINE) return {4'h0, edp, eoe, edm, eoe};
    return {4'h0, t[c]};
  endfunction
  task automatic wake(input logic [7:0] sv, input logic rem, input logic ek);
    int h;
    int w;
    h = 0;
    w = 0;
    sk = 1'b0;
    bus(1'b1, hpsr_pkg::IDX_SUSP, sv, 1'b1);
    hsusp <= 1'b1;
    tick(2);
    if (rem) mk[1] <= 1'b1;
    else conn[2] <= 1'b1;
    tick(1);
    conn <= 4'h0;
    repeat (40) begin
      tick(1);
      if (fwh === 1'b1) h++;
      if (wclk === 1'b1) w++;
      if (fwh === 1'b1) mk <= 4'h0;
      if (fwh === 1'b1) hsusp <= 1'b0;
      if (nm(up) == 8'h07 && nm(dn[0]) == (ls[0] ? 8'h0d : 8'h07))
        sk = 1'b1;
    end
    mk <= 4'h0;
    hsusp <= 1'b0;
    tick(HOLD + 5);
    chk({7'h00, sk}, {7'h00, ek});
    if (ek) chk(8'(h), 8'(HOLD + 1));
    if (ek) chk(8'(w), 8'(HOLD + 1));
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    tick(20000);
    miscompares++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    tick(3);
    rstn <= 1'b1;
    tick(1);
    rdchk(hpsr_pkg::IDX_USC, 8'h00);
    rdchk(hpsr_pkg::IDX_SUSP, 8'h00);
    rdchk(hpsr_pkg::IDX_RES, 8'h00);
    rdchk(8'h20, 8'h00);
    repeat (3) begin
      d = 8'($random(seed));
      updp <= 1'($random(seed));
      updm <= 1'($random(seed));
      bus(1'b1, hpsr_pkg::IDX_USC, d & 8'hf8, 1'b1);
      rdchk(hpsr_pkg::IDX_USC, {d[7:6], updp, updm, 4'h0});
    end
    d = {d[7:6], updp, updm, 4'h8};
    eact <= 1'b1;
    tick(1);
    eact <= 1'b0;
    bus(1'b1, hpsr_pkg::IDX_USC, d, 1'b1);
    rdchk(hpsr_pkg::IDX_USC, d);
    bus(1'b1, hpsr_pkg::IDX_USC, 8'h00, 1'b0);
    rdchk(hpsr_pkg::IDX_USC, d);
    bus(1'b1, hpsr_pkg::IDX_USC, d & 8'hf7, 1'b1);
    rdchk(hpsr_pkg::IDX_USC, d & 8'hf7);
    eoe <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      edp <= 1'($random(seed));
      edm <= 1'($random(seed));
      bus(1'b1, hpsr_pkg::IDX_USC, 8'(c), 1'b1);
      tick(2);
      chk(nm(up), drv(3'(c)));
    end
    bus(1'b1, hpsr_pkg::IDX_USC, 8'h00, 1'b1);
    eoe <= 1'b0;
    den <= 4'he; // the forced port is disabled first
    for (int c = 1; c < 4; c++) begin
      frc <= {6'h00, 2'(c)};
      tick(3);
      chk(nm(dn[0]), drv(3'(c)));
    end
    frc <= 8'h00;
    den <= 4'hf;
    repeat (4) begin
      p = $unsigned($random(seed)) % 4;
      ls <= 4'($random(seed));
      tick(3); // new idle level must pass the pin synchronisers first
      bus(1'b1, hpsr_pkg::IDX_SUSP, 8'(1 << p), 1'b1);
      tick(4);
      rdchk(hpsr_pkg::IDX_RES, 8'h00);
      mk[p] <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      chk({7'h00, irq}, 8'h01);
      tick(1);
      chk(nm(dn[p]), ls[p] ? 8'h0d : 8'h07);
      mk[p] <= 1'b0;
      rdchk(hpsr_pkg::IDX_RES, 8'(1 << p));
      bus(1'b1, hpsr_pkg::IDX_SUSP, 8'h00, 1'b1);
      rdchk(hpsr_pkg::IDX_RES, 8'h00);
      chk(nm(dn[p]), 8'h00);
    end
    p = $unsigned($random(seed)) % 4;
    bus(1'b1, hpsr_pkg::IDX_SUSP, 8'h8f, 1'b1);
    disc[p] <= 1'b1;
    mse0[p] <= 1'b1;
    tick(1);
    disc <= 4'h0;
    rdchk(hpsr_pkg::IDX_SUSP, 8'h8f & ~8'(1 << p));
    mse0 <= 4'h0;
    busrst <= 1'b1;
    tick(1);
    busrst <= 1'b0;
    rdchk(hpsr_pkg::IDX_SUSP, 8'h00);
    wake(8'h00, 1'b0, 1'b0);
    wake(8'h80, 1'b0, 1'b1);
    wake(8'h00, 1'b1, 1'b1);
    rpt_oe <= 1'b1;
    eof1 <= 1'b1;
    tick(1);
    eof1 <= 1'b0;
    sk = 1'b0;
    repeat (3) begin
      tick(1);
      if (nm(dn[0]) == 8'h05) sk = 1'b1;
    end
    chk({7'h00, sk}, 8'h01);
    report_and_stop();
  end
endmodule
bind hpsr_ctrl hpsr_ctrl_chk #(.WAKE_HOLD_CYC(WAKE_HOLD_CYC)) hpsr_ctrl_chk_i (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_hub_irq(o_hub_irq),
  .o_wake_clocks(o_wake_clocks), .o_fw_hold(o_fw_hold));
`default_nettype wire
